/* File: panel_ctrl_ext_pkg.sv */
// Purpose: Shared constants and types for the extended panel control register bank
// Assumes: Registers reached by index through the sequencer data port
// Notes:   Reset values, masks and field positions
// Summary of operation
// - Frame-buffer writes gated by arbitration write bit in single/simul mode
// - Lock bit 6 clear allows vertical end writes
// - Lock bit 4 clear allows horizontal end writes
// - Enhanced expansion used in 400-line text only
// - Expansion code: x0 none, 01 three, 11 split
// - Extender mode turns video pins into palette inputs
// - Bit 5 copies sync onto line and frame pulses
// - Bit 4 kills pixel clock; blank/data in CRT-only
// - Bit 3 forces both sync outputs low
// - Dither mode from bits 6,2 plus external bits
// - Clock selection writable only with key 101
// - Video clock from dot select and misc bits; 0000 unless internal clock mode
// - Memory clock select field drives clock generator
// - N-value used only when video select is 0010
// - Override bit takes latches from force bits
// - Force bits map to five supplies, 1 is 3.3V
// - Refresh divisor register, bit 0 included, holds n minus one
// - Bit 0 clear passes slow clock through
// - Status detect enabled by bit 7, source 6:5
// - Bit 4 selects status detect polarity
// - Status bits 2:0 report three voltage mode latches
package panel_ctrl_ext_pkg;

  localparam logic [7:0] IDX_FB_RW_CTRL    = 8'h25;
  localparam logic [7:0] IDX_CRT_LOCK_TWO  = 8'h27;
  localparam logic [7:0] IDX_FUTURE_RSVD   = 8'h28;
  localparam logic [7:0] IDX_FEATURE_THREE = 8'h29;
  localparam logic [7:0] IDX_CLOCK_SEL     = 8'h31;
  localparam logic [7:0] IDX_N_VALUE       = 8'h32;
  localparam logic [7:0] IDX_VOLT_OVR      = 8'h33;
  localparam logic [7:0] IDX_REFRESH_DIV   = 8'h34;
  localparam logic [7:0] IDX_CLOCK_UNLOCK  = 8'h35;
  localparam logic [7:0] IDX_STATUS_DET    = 8'h36;

  // Writable bits; zero is reserved or read-only
  localparam logic [7:0] MASK_FB_RW_CTRL    = 8'hFF;
  localparam logic [7:0] MASK_CRT_LOCK_TWO  = 8'h53;
  localparam logic [7:0] MASK_FEATURE_THREE = 8'hFC;
  localparam logic [7:0] MASK_CLOCK_SEL     = 8'h1F;
  localparam logic [7:0] MASK_N_VALUE       = 8'hFF;
  localparam logic [7:0] MASK_VOLT_OVR      = 8'h3F;
  localparam logic [7:0] MASK_REFRESH_DIV   = 8'hFF;
  localparam logic [7:0] MASK_CLOCK_UNLOCK  = 8'h70;
  localparam logic [7:0] MASK_STATUS_DET    = 8'hF0;

  localparam logic [7:0] RESET_REG = 8'h00;

  localparam int BIT_FB_WRITE     = 0;
  localparam int BIT_FB_READ      = 1;
  localparam int BIT_LOCK_VERT    = 6;
  localparam int BIT_LOCK_HORIZ   = 4;
  localparam int BIT_AUX_EXT      = 7;
  localparam int BIT_DITHER_HI    = 6;
  localparam int BIT_SYNC_TO_PULSE = 5;
  localparam int BIT_PIXEL_OFF    = 4;
  localparam int BIT_SYNC_OFF     = 3;
  localparam int BIT_DITHER_LO    = 2;
  localparam int BIT_OVERRIDE     = 5;
  localparam int BIT_DETECT_EN    = 7;
  localparam int BIT_DETECT_POL   = 4;
  localparam int BIT_REFRESH_DIV_ON = 0;

  localparam logic [2:0] CLOCK_UNLOCK_KEY = 3'b101;
  localparam logic [3:0] N_VALUE_SELECT = 4'h2;
  localparam int REFRESH_CYCLE_PERIODS = 8;

  typedef enum logic [1:0] {
    EXP_NONE      = 2'b00,
    EXP_THREE_BELOW = 2'b01,
    EXP_SPLIT     = 2'b11
  } expansion_mode_t;

  typedef struct packed {
    logic       pixel_clock;
    logic       blank;
    logic [7:0] video_data;
  } video_pins_t;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic line_pulse;
    logic frame_pulse;
  } sync_pins_t;

endpackage

/* File: panel_ctrl_ext_regs.sv */
// Purpose: Extended indexed configuration registers and their output gating
// Assumes: All inputs synchronous to clk_sys_in
// Notes:   Reads return data one clock after rd_en_in; unmapped indexes read zero
`timescale 1ns/100ps
module panel_ctrl_ext_regs (
  input  wire logic                             clk_sys_in,
  input  wire logic                             resetn_in,
  // Sequencer data port
  input  wire logic [7:0]                       seq_index_in,
  input  wire logic [7:0]                       seq_wdata_in,
  input  wire logic                             seq_wr_en_in,
  input  wire logic                             seq_rd_en_in,
  output logic [7:0]                            seq_rdata_out,
  output logic                                  seq_index_hit_out,
  // Values from neighbouring registers
  input  wire logic                             single_simul_mode_in,
  input  wire logic                             text_400_line_in,
  input  wire logic [1:0]                       panel_control_reg_exp_in,
  input  wire logic [1:0]                       dither_control_reg_mode_in,
  input  wire logic                             dither_control_reg_refresh_in,
  input  wire logic                             arbitration_setup_reg_tft_in,
  input  wire logic [1:0]                       misc_output_clock_in,
  input  wire logic                             internal_pixel_clock_mode_in,
  input  wire logic                             crt_only_mode_in,
  // Controls to neighbouring logic
  output logic                                  fb_write_allow_out,
  output logic                                  fb_read_allow_out,
  output logic                                  vertical_display_end_wr_allow_out,
  output logic                                  horizontal_display_end_wr_allow_out,
  output panel_ctrl_ext_pkg::expansion_mode_t   text_expansion_out,
  output logic [1:0]                            panel_expansion_out,
  output logic [4:0]                            tft_dither_mode_out,
  output logic [3:0]                            video_clock_select_out,
  output logic [2:0]                            memory_clock_select_out,
  output logic [7:0]                            video_clock_n_value_out,
  output logic                                  video_clock_n_enable_out,
  // Voltage mode latches
  input  wire logic [4:0]                       voltage_detect_in,
  output logic [4:0]                            voltage_mode_out,
  // Refresh timing
  input  wire logic                             slow_clock_input_in,
  output logic                                  refresh_request_out,
  // Bus activity detect
  input  wire logic                             io_access_in,
  input  wire logic                             mem_access_in,
  output logic                                  status_detect_output_out,
  // Internal video sources
  input  wire panel_ctrl_ext_pkg::video_pins_t  video_int_in,
  input  wire panel_ctrl_ext_pkg::sync_pins_t   sync_int_in,
  // Video pins, enable low while driving
  input  wire panel_ctrl_ext_pkg::video_pins_t  video_data_pins_in,
  output panel_ctrl_ext_pkg::video_pins_t       video_data_pins_out,
  output logic                                  video_data_pins_oe_n_out,
  output panel_ctrl_ext_pkg::sync_pins_t        sync_pins_out,
  // Palette converter feed
  output panel_ctrl_ext_pkg::video_pins_t       palette_feed_out
);

  logic       rst_meta;
  logic       rst_sync_n;
  logic [7:0] fb_rw_ctrl;
  logic [7:0] crt_lock_control_two;
  logic [7:0] feature_three;
  logic [7:0] clock_selection;
  logic [7:0] video_clock_n_value;
  logic [7:0] voltage_override;
  logic [7:0] refresh_divider;
  logic [7:0] clock_unlock;
  logic [7:0] status_detect;
  logic [7:0] next_rdata;
  logic       slow_prev;
  logic       slow_rise;
  logic [10:0] refresh_count;
  logic [10:0] refresh_limit;
  logic [2:0]  refresh_width;
  logic        refresh_pulse;
  logic        detect_active;
  logic        aux_mode;

  // Reserved and read-only bits keep old value
  function automatic logic [7:0] merge_write(input logic [7:0] old_val,
                                             input logic [7:0] new_val,
                                             input logic [7:0] mask);
    merge_write = (old_val & ~mask) | (new_val & mask);
  endfunction

  function automatic logic write_hit(input logic [7:0] idx);
    write_hit = seq_wr_en_in && (seq_index_in == idx);
  endfunction

  // Reset release through two stages
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fb_rw_ctrl <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_FB_RW_CTRL)) begin
      fb_rw_ctrl <= merge_write(fb_rw_ctrl, seq_wdata_in, panel_ctrl_ext_pkg::MASK_FB_RW_CTRL);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      crt_lock_control_two <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_CRT_LOCK_TWO)) begin
      crt_lock_control_two <= merge_write(crt_lock_control_two, seq_wdata_in,
                                          panel_ctrl_ext_pkg::MASK_CRT_LOCK_TWO);
    end
  end

  // Low bits stay zero whatever software writes
  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      feature_three <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_FEATURE_THREE)) begin
      feature_three <= merge_write(feature_three, seq_wdata_in,
                                   panel_ctrl_ext_pkg::MASK_FEATURE_THREE);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clock_selection <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_CLOCK_SEL) &&
                 clock_unlock[6:4] == panel_ctrl_ext_pkg::CLOCK_UNLOCK_KEY) begin
      clock_selection <= merge_write(clock_selection, seq_wdata_in,
                                     panel_ctrl_ext_pkg::MASK_CLOCK_SEL);
    end
  end

  // Any value stored; range is software's duty
  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      video_clock_n_value <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_N_VALUE)) begin
      video_clock_n_value <= merge_write(video_clock_n_value, seq_wdata_in,
                                         panel_ctrl_ext_pkg::MASK_N_VALUE);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      voltage_override <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_VOLT_OVR)) begin
      voltage_override <= merge_write(voltage_override, seq_wdata_in,
                                      panel_ctrl_ext_pkg::MASK_VOLT_OVR);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      refresh_divider <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_REFRESH_DIV)) begin
      refresh_divider <= merge_write(refresh_divider, seq_wdata_in,
                                     panel_ctrl_ext_pkg::MASK_REFRESH_DIV);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clock_unlock <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_CLOCK_UNLOCK)) begin
      clock_unlock <= merge_write(clock_unlock, seq_wdata_in,
                                  panel_ctrl_ext_pkg::MASK_CLOCK_UNLOCK);
    end
  end

  // Bits 2:0 read live from the latches
  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_detect <= panel_ctrl_ext_pkg::RESET_REG;
    end else if (write_hit(panel_ctrl_ext_pkg::IDX_STATUS_DET)) begin
      status_detect <= merge_write(status_detect, seq_wdata_in,
                                   panel_ctrl_ext_pkg::MASK_STATUS_DET);
    end
  end

  // Read path
  always_comb begin
    seq_index_hit_out = 1'b1;
    unique case (seq_index_in)
      panel_ctrl_ext_pkg::IDX_FB_RW_CTRL:    next_rdata = fb_rw_ctrl;
      panel_ctrl_ext_pkg::IDX_CRT_LOCK_TWO:  next_rdata = crt_lock_control_two;
      panel_ctrl_ext_pkg::IDX_FUTURE_RSVD:   next_rdata = 8'h00;
      panel_ctrl_ext_pkg::IDX_FEATURE_THREE: next_rdata = feature_three;
      panel_ctrl_ext_pkg::IDX_CLOCK_SEL:     next_rdata = clock_selection;
      panel_ctrl_ext_pkg::IDX_N_VALUE:       next_rdata = video_clock_n_value;
      panel_ctrl_ext_pkg::IDX_VOLT_OVR:      next_rdata = voltage_override;
      panel_ctrl_ext_pkg::IDX_REFRESH_DIV:   next_rdata = refresh_divider;
      panel_ctrl_ext_pkg::IDX_CLOCK_UNLOCK:  next_rdata = clock_unlock;
      panel_ctrl_ext_pkg::IDX_STATUS_DET: begin
        // Analog, panel, pixel supply latches on bits 2:0
        next_rdata = {status_detect[7:4], 1'b0,
                      voltage_mode_out[0], voltage_mode_out[2], voltage_mode_out[4]};
      end
      default: begin
        next_rdata        = 8'h00;
        seq_index_hit_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seq_rdata_out <= 8'h00;
    end else if (seq_rd_en_in) begin
      seq_rdata_out <= next_rdata;
    end
  end

  // Frame-buffer arbitration and CRT timing unlocks
  always_comb begin
    fb_write_allow_out = !single_simul_mode_in ||
                         fb_rw_ctrl[panel_ctrl_ext_pkg::BIT_FB_WRITE];
    fb_read_allow_out  = !single_simul_mode_in ||
                         fb_rw_ctrl[panel_ctrl_ext_pkg::BIT_FB_READ];
    vertical_display_end_wr_allow_out =
      !crt_lock_control_two[panel_ctrl_ext_pkg::BIT_LOCK_VERT];
    horizontal_display_end_wr_allow_out =
      !crt_lock_control_two[panel_ctrl_ext_pkg::BIT_LOCK_HORIZ];
  end

  // Text expansion, dither mode and clock selects
  always_comb begin
    panel_expansion_out = panel_control_reg_exp_in;
    if (!text_400_line_in || !crt_lock_control_two[0]) begin
      text_expansion_out = panel_ctrl_ext_pkg::EXP_NONE;
    end else if (crt_lock_control_two[1]) begin
      text_expansion_out = panel_ctrl_ext_pkg::EXP_SPLIT;
    end else begin
      text_expansion_out = panel_ctrl_ext_pkg::EXP_THREE_BELOW;
    end
    tft_dither_mode_out = {feature_three[panel_ctrl_ext_pkg::BIT_DITHER_HI],
                           feature_three[panel_ctrl_ext_pkg::BIT_DITHER_LO],
                           dither_control_reg_mode_in,
                           arbitration_setup_reg_tft_in};
    video_clock_select_out   = internal_pixel_clock_mode_in ?
                               {clock_selection[4:3], misc_output_clock_in} : 4'h0;
    memory_clock_select_out  = clock_selection[2:0];
    video_clock_n_value_out  = video_clock_n_value;
    video_clock_n_enable_out = (video_clock_select_out ==
                                panel_ctrl_ext_pkg::N_VALUE_SELECT);
  end

  // Voltage latches, bit 4 pixel supply to bit 0 analog
  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      voltage_mode_out <= 5'h00;
    end else if (voltage_override[panel_ctrl_ext_pkg::BIT_OVERRIDE]) begin
      voltage_mode_out <= voltage_override[4:0];
    end else begin
      voltage_mode_out <= voltage_detect_in;
    end
  end

  // Refresh counts slow input rising edges
  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      slow_prev <= 1'b0;
    end else begin
      slow_prev <= slow_clock_input_in;
    end
  end

  assign slow_rise     = slow_clock_input_in && !slow_prev;
  // Divisor 8*(n+1)
  assign refresh_limit = {refresh_divider, 3'b000} + 11'h007;

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      refresh_count <= 11'h000;
      refresh_width <= 3'h0;
      refresh_pulse <= 1'b0;
    end else if (slow_rise) begin
      if (refresh_count >= refresh_limit) begin
        refresh_count <= 11'h000;
      end else begin
        refresh_count <= refresh_count + 11'h001;
      end
      // Pulse spans eight slow periods
      if (refresh_count == 11'h000) begin
        refresh_pulse <= 1'b1;
        refresh_width <= 3'h0;
      end else if (refresh_width ==
                   3'(panel_ctrl_ext_pkg::REFRESH_CYCLE_PERIODS - 1)) begin
        refresh_pulse <= 1'b0;
      end else begin
        refresh_width <= refresh_width + 3'h1;
      end
    end
  end

  // Otherwise slow input passes through
  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      refresh_request_out <= 1'b0;
    end else if (dither_control_reg_refresh_in &&
                 refresh_divider[panel_ctrl_ext_pkg::BIT_REFRESH_DIV_ON]) begin
      refresh_request_out <= refresh_pulse;
    end else begin
      refresh_request_out <= slow_clock_input_in;
    end
  end

  // Bus activity detect; source code 00 never asserts
  assign detect_active = status_detect[panel_ctrl_ext_pkg::BIT_DETECT_EN] &&
                         ((status_detect[5] && io_access_in) ||
                          (status_detect[6] && mem_access_in));

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_detect_output_out <= 1'b0;
    end else begin
      status_detect_output_out <= detect_active ^
                                  status_detect[panel_ctrl_ext_pkg::BIT_DETECT_POL];
    end
  end

  // Video pin gating
  assign aux_mode = feature_three[panel_ctrl_ext_pkg::BIT_AUX_EXT];

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      video_data_pins_oe_n_out <= 1'b1;
      palette_feed_out         <= '0;
    end else begin
      video_data_pins_oe_n_out <= aux_mode;
      palette_feed_out         <= aux_mode ? video_data_pins_in : video_int_in;
    end
  end

  // Combinational so pixel clock is not delayed
  always_comb begin
    video_data_pins_out.pixel_clock = video_int_in.pixel_clock &&
                                      !feature_three[panel_ctrl_ext_pkg::BIT_PIXEL_OFF];
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      video_data_pins_out.blank      <= 1'b0;
      video_data_pins_out.video_data <= 8'h00;
    end else if (feature_three[panel_ctrl_ext_pkg::BIT_PIXEL_OFF] && crt_only_mode_in) begin
      video_data_pins_out.blank      <= 1'b0;
      video_data_pins_out.video_data <= 8'h00;
    end else begin
      video_data_pins_out.blank      <= video_int_in.blank;
      video_data_pins_out.video_data <= video_int_in.video_data;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync_pins_out <= '0;
    end else begin
      if (feature_three[panel_ctrl_ext_pkg::BIT_SYNC_OFF]) begin
        sync_pins_out.hsync <= 1'b0;
        sync_pins_out.vsync <= 1'b0;
      end else begin
        sync_pins_out.hsync <= sync_int_in.hsync;
        sync_pins_out.vsync <= sync_int_in.vsync;
      end
      if (feature_three[panel_ctrl_ext_pkg::BIT_SYNC_TO_PULSE]) begin
        sync_pins_out.line_pulse  <= sync_int_in.hsync;
        sync_pins_out.frame_pulse <= sync_int_in.vsync;
      end else begin
        sync_pins_out.line_pulse  <= sync_int_in.line_pulse;
        sync_pins_out.frame_pulse <= sync_int_in.frame_pulse;
      end
    end
  end

endmodule // panel_ctrl_ext_regs

/* File: panel_ctrl_ext_checker.sv */
// Purpose: Port assertions for the extended register bank
// Assumes: One clock domain, reset active low
// Notes:   Clock key is tracked from host writes
`timescale 1ns/100ps
module panel_ctrl_ext_checker (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [7:0] seq_index_in,
  input wire logic [7:0] seq_wdata_in,
  input wire logic seq_wr_en_in,
  input wire logic single_simul_mode_in,
  input wire logic fb_write_allow_out,
  input wire logic text_400_line_in,
  input wire panel_ctrl_ext_pkg::expansion_mode_t text_expansion_out,
  input wire logic internal_pixel_clock_mode_in,
  input wire logic [1:0] misc_output_clock_in,
  input wire logic [3:0] video_clock_select_out,
  input wire logic video_clock_n_enable_out,
  input wire logic [2:0] memory_clock_select_out,
  input wire logic [4:0] voltage_mode_out
);
  logic [2:0] key;
  wire w31 = seq_wr_en_in && seq_index_in == panel_ctrl_ext_pkg::IDX_CLOCK_SEL;
  wire w33 = seq_wr_en_in && seq_index_in == panel_ctrl_ext_pkg::IDX_VOLT_OVR;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) key <= 3'h0;
    else if (seq_wr_en_in && seq_index_in == 8'h35) key <= seq_wdata_in[6:4];
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  a_fb_write_open: assert property (!single_simul_mode_in |-> fb_write_allow_out)
    else $error("fb write blocked");
  a_exp_text_only: assert property (!text_400_line_in |-> text_expansion_out == 2'b00)
    else $error("expansion not 400-line");
  a_exp_code_legal: assert property (text_expansion_out != 2'b10)
    else $error("illegal expansion code");
  a_video_clock_misc_bits: assert property (internal_pixel_clock_mode_in |->
    video_clock_select_out[1:0] == misc_output_clock_in) else $error("video clock misc bits");
  a_n_value_gate: assert property (video_clock_n_enable_out == (video_clock_select_out == 4'h2))
    else $error("n-value enable wrong");
  a_clock_key_open: assert property (w31 && key == 3'b101 |=>
    memory_clock_select_out == $past(seq_wdata_in[2:0])) else $error("unlocked write lost");
  a_clock_key_shut: assert property (w31 && key != 3'b101 |=> $stable(memory_clock_select_out))
    else $error("locked write taken");
  a_force_volt_mode: assert property (w33 && seq_wdata_in[5] ##1 !w33 |=>
    voltage_mode_out == $past(seq_wdata_in[4:0], 2)) else $error("override not applied");
  c_unlock_write: cover property (w31 && key == 3'b101);
  c_override: cover property (w33 && seq_wdata_in[5]);
  c_expansion_split: cover property (text_expansion_out == 2'b11);
endmodule // panel_ctrl_ext_checker
bind panel_ctrl_ext_regs panel_ctrl_ext_checker chk_i (.*);

/* File: panel_ctrl_ext_regs_bench.sv */
// Purpose: Self-checking bench for the register bank
// Assumes: Inputs change at the falling clock edge
// Notes:   Refresh checked by counting high cycles
`timescale 1ns/100ps
module panel_ctrl_ext_regs_bench;
  logic clk_sys_in = 1'b0;
  logic resetn_in, seq_wr_en_in, seq_rd_en_in, single_simul_mode_in, text_400_line_in;
  logic crt_only_mode_in, dither_control_reg_refresh_in, arbitration_setup_reg_tft_in;
  logic internal_pixel_clock_mode_in, slow_clock_input_in, io_access_in, mem_access_in;
  logic seq_index_hit_out, fb_write_allow_out, fb_read_allow_out, video_clock_n_enable_out;
  logic vertical_display_end_wr_allow_out, horizontal_display_end_wr_allow_out;
  logic refresh_request_out, status_detect_output_out, video_data_pins_oe_n_out;
  logic [7:0] seq_index_in, seq_wdata_in, seq_rdata_out, video_clock_n_value_out, d, f;
  logic [1:0] panel_control_reg_exp_in, dither_control_reg_mode_in, misc_output_clock_in, panel_expansion_out;
  logic [4:0] tft_dither_mode_out, voltage_detect_in, voltage_mode_out;
  logic [3:0] video_clock_select_out;
  logic [2:0] memory_clock_select_out;
  panel_ctrl_ext_pkg::expansion_mode_t text_expansion_out;
  panel_ctrl_ext_pkg::video_pins_t video_int_in, video_data_pins_in, video_data_pins_out, palette_feed_out;
  panel_ctrl_ext_pkg::sync_pins_t sync_int_in, sync_pins_out;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 32'hd92a;
  logic [7:0] idxs [9] = '{8'h25, 8'h27, 8'h28, 8'h29, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35};
  logic [7:0] msk [9] = '{8'hFF, 8'h53, 8'h00, 8'hFC, 8'h00, 8'hFF, 8'h3F, 8'hFF, 8'h70};
  logic [7:0] fset [5] = '{8'h08, 8'h20, 8'h10, 8'h80, 8'h44};
  panel_ctrl_ext_regs uut (.*);
  always #12.5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(negedge clk_sys_in);
    seq_index_in = i;
    seq_wdata_in = v;
    seq_wr_en_in = 1'b1;
    @(negedge clk_sys_in);
    seq_wr_en_in = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk_sys_in);
    seq_index_in = i;
    seq_rd_en_in = 1'b1;
    @(negedge clk_sys_in);
    seq_rd_en_in = 1'b0;
    chk(16'({seq_index_hit_out, seq_rdata_out}), 16'({1'b1, e}));
  endtask
  function automatic panel_ctrl_ext_pkg::sync_pins_t exp_sync(input logic [7:0] v);
    exp_sync = sync_int_in;
    if (v[3]) {exp_sync.hsync, exp_sync.vsync} = 2'b00;
    if (v[5]) {exp_sync.line_pulse, exp_sync.frame_pulse} = {sync_int_in.hsync, sync_int_in.vsync};
  endfunction
  function automatic panel_ctrl_ext_pkg::video_pins_t exp_vid(input logic [7:0] v);
    exp_vid = video_int_in;
    exp_vid.pixel_clock = video_int_in.pixel_clock & !v[4];
    if (v[4] && crt_only_mode_in) exp_vid[8:0] = 9'h000;
  endfunction
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    mismatches++;
    results();
  end
  initial begin
    {resetn_in, seq_wr_en_in, seq_rd_en_in, seq_index_in, seq_wdata_in, single_simul_mode_in,
      text_400_line_in, crt_only_mode_in, dither_control_reg_refresh_in, slow_clock_input_in,
      arbitration_setup_reg_tft_in, internal_pixel_clock_mode_in, io_access_in, mem_access_in,
      panel_control_reg_exp_in, dither_control_reg_mode_in, misc_output_clock_in,
      voltage_detect_in, video_int_in, video_data_pins_in, sync_int_in} = '0;
    repeat (16) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    for (int k = 0; k < 9; k++) rdc(idxs[k], 8'h00);
    for (int k = 0; k < 9; k++) begin
      d = $random(seed);
      if (k == 3) d[1:0] = 2'b00;
      if (k == 5) d = 8'h38 + d[6:0];
      wr(idxs[k], d);
      rdc(idxs[k], d & msk[k]);
    end
    $display("Register access test done");
    wr(8'h35, 8'h50);
    d = $random(seed);
    wr(8'h31, d);
    chk(16'(memory_clock_select_out), 16'(d[2:0]));
    rdc(8'h31, d & 8'h1F);
    {internal_pixel_clock_mode_in, misc_output_clock_in} = 3'b110;
    wr(8'h31, 8'h00);
    chk(16'({video_clock_select_out, video_clock_n_enable_out}), 16'h0005);
    wr(8'h35, 8'h00);
    wr(8'h31, 8'h1F);
    rdc(8'h31, 8'h00);
    single_simul_mode_in = 1'b1;
    text_400_line_in = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h25, 8'(c));
      chk(16'({fb_read_allow_out, fb_write_allow_out}), 16'(c));
      wr(8'h27, 8'(c) | (c[1] ? 8'h50 : 8'h00));
      chk(16'({vertical_display_end_wr_allow_out, horizontal_display_end_wr_allow_out,
        text_expansion_out}), 16'({!c[1], !c[1], c[0] ? 2'(c) : 2'b00}));
    end
    $display("Clock and lock test done");
    for (int k = 0; k < 5; k++) begin
      f = fset[k];
      {sync_int_in, video_int_in, video_data_pins_in} = $random(seed);
      {panel_control_reg_exp_in, crt_only_mode_in, dither_control_reg_mode_in,
        arbitration_setup_reg_tft_in} = $random(seed);
      wr(8'h29, f);
      @(negedge clk_sys_in);
      chk(16'(sync_pins_out), 16'(exp_sync(f)));
      chk(16'(video_data_pins_out), 16'(exp_vid(f)));
      chk(16'({video_data_pins_oe_n_out, palette_feed_out}),
        16'({f[7], f[7] ? video_data_pins_in : video_int_in}));
      chk(16'({panel_expansion_out, tft_dither_mode_out}), 16'({panel_control_reg_exp_in, f[6],
        f[2], dither_control_reg_mode_in, arbitration_setup_reg_tft_in}));
    end
    $display("Feature test done");
    voltage_detect_in = $random(seed);
    wr(8'h33, 8'h00);
    @(negedge clk_sys_in);
    chk(16'(voltage_mode_out), 16'(voltage_detect_in));
    d = $random(seed);
    wr(8'h33, {3'b001, d[4:0]});
    @(negedge clk_sys_in);
    chk(16'(voltage_mode_out), 16'(d[4:0]));
    for (int k = 0; k < 6; k++) begin
      f = $random(seed);
      {io_access_in, mem_access_in} = f[1:0];
      wr(8'h36, f);
      @(negedge clk_sys_in);
      chk(16'(status_detect_output_out),
        16'((f[7] & (f[5] & f[1] | f[6] & f[0])) ^ f[4]));
      rdc(8'h36, {f[7:4], 1'b0, d[0], d[2], d[4]});
    end
    $display("Voltage and detect test done");
    wr(8'h34, 8'h01);
    {dither_control_reg_refresh_in, d} = 9'h100;
    for (int i = 0; i < 96; i++) begin
      @(negedge clk_sys_in);
      if (i > 31) d += 8'(refresh_request_out);
      slow_clock_input_in = i[0];
    end
    chk(16'(d), 16'd32);
    dither_control_reg_refresh_in = 1'b0;
    @(negedge clk_sys_in);
    chk(16'(refresh_request_out), 16'(slow_clock_input_in));
    $display("Refresh test done");
    results();
  end
endmodule // panel_ctrl_ext_regs_bench
